// File: pkg/srs_pkg.sv
/*
 * Package for the supply reset supervisor: timing constants, counter
 * widths and the state encoding.
 * Assumes a single 250 MHz clock; all times except the release delay bounds become cycle counts here.
 */
`default_nettype none
package srs_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // Release delay nominal 200 ms, bounds 130 ms .. 270 ms
    localparam int unsigned RELEASE_DELAY_MS = 200;
    localparam int unsigned RELEASE_DELAY_MIN_MS = 130;
    localparam int unsigned RELEASE_DELAY_MAX_MS = 270;
    localparam longint unsigned RELEASE_DELAY_CYC = 64'(RELEASE_DELAY_MS) * 1000 * CLK_MHZ;
    // Undervoltage to reset assertion, at most 5 us
    localparam int unsigned TRIP_DELAY_US = 5;
    localparam int unsigned TRIP_DELAY_CYC = TRIP_DELAY_US * CLK_MHZ;
    // Supply glitch reject 30 ns (longest ignored, round down)
    localparam int unsigned SUPPLY_GLITCH_NS = 30;
    localparam int unsigned SUPPLY_GLITCH_CYC = (SUPPLY_GLITCH_NS * CLK_MHZ) / 1000;
    // Push-button glitch immunity 100 ns
    localparam int unsigned BUTTON_GLITCH_NS = 100;
    localparam int unsigned BUTTON_GLITCH_CYC = (BUTTON_GLITCH_NS * CLK_MHZ) / 1000;
    // Programming cycle time 5 ms
    localparam int unsigned PROGRAM_CYCLE_MS = 5;
    localparam longint unsigned PROGRAM_CYCLE_CYC = 64'(PROGRAM_CYCLE_MS) * 1000 * CLK_MHZ;
    localparam int unsigned TIMER_W = 27;
    localparam int unsigned FILT_W = 5;
    typedef enum logic [1:0] {
        SRS_HOLD = 2'b00,
        SRS_TIMING = 2'b01,
        SRS_RUN = 2'b10
    } srs_state_e;
endpackage : srs_pkg
`default_nettype wire

// File: core/srs_filter.sv
/*
 * Glitch filter: the output follows the input only after the input has
 * held a new level for more than LIMIT cycles.
 * Assumes the input is synchronous to clk.
 */
`default_nettype none
module srs_filter
    import srs_pkg::*;
#(
    parameter logic [FILT_W-1:0] LIMIT = 5'h07,
    parameter logic INIT = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic raw,
    output logic clean
);
    logic [FILT_W-1:0] cnt;
    logic [FILT_W-1:0] next_cnt;
    logic next_clean;

    always_comb begin
        next_cnt = '0;
        next_clean = clean;
        if (raw != clean) begin
            // Only a level that outlasts LIMIT cycles gets through
            if (cnt >= LIMIT) begin
                next_clean = raw;
            end else begin
                next_cnt = cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= '0;
            clean <= INIT;
        end else begin
            cnt <= next_cnt;
            clean <= next_clean;
        end
    end
endmodule : srs_filter
`default_nettype wire

// File: core/srs_supervisor.sv
/*
 * Supply reset supervisor: holds the open-drain reset pin while the supply
 * is low and for the release delay after, takes a filtered push-button
 * restart on the active-low variant, and gates the EEPROM engine.
 * Assumes synchronous inputs; the pin level is resolved outside.
 */
`default_nettype none
module srs_supervisor
    import srs_pkg::*;
#(
    parameter bit ACTIVE_LOW = 1'b1,
    parameter logic [TIMER_W-1:0] RELEASE_COUNT = TIMER_W'(RELEASE_DELAY_CYC),
    parameter logic [TIMER_W-1:0] PROGRAM_COUNT = TIMER_W'(PROGRAM_CYCLE_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic under_trip_level,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic reset_active,
    input wire logic xfer_busy,
    input wire logic program_request,
    output logic xfer_abort,
    output logic bus_disable,
    output logic program_start,
    output logic program_busy
);
    srs_state_e state;
    srs_state_e next_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic [TIMER_W-1:0] prog_timer;
    logic [TIMER_W-1:0] next_prog_timer;
    logic next_program_start;
    logic under_clean;
    logic button_low;
    logic button_prev;
    logic button_fall;

    // Supply comparator filtered so short dips never reach the state machine
    srs_filter #(.LIMIT(FILT_W'(SUPPLY_GLITCH_CYC)), .INIT(1'b1)) u_supply_filt (
        .clk(clk),
        .rst(rst),
        .raw(under_trip_level),
        .clean(under_clean)
    );

    // Pin read as "pin low"; only meaningful on the active-low variant
    srs_filter #(.LIMIT(FILT_W'(BUTTON_GLITCH_CYC)), .INIT(1'b0)) u_button_filt (
        .clk(clk),
        .rst(rst),
        .raw(~reset_pin_in),
        .clean(button_low)
    );

    // Own drive would look like a press, so edges count only while released
    assign button_fall = ACTIVE_LOW && button_low && !button_prev && state == SRS_RUN;

    always_comb begin
        next_state = state;
        next_timer = timer;
        if (under_clean) begin
            next_state = SRS_HOLD;
            next_timer = '0;
        end else begin
            unique case (state)
                SRS_HOLD: begin
                    next_state = SRS_TIMING;
                    next_timer = '0;
                end
                SRS_TIMING: begin
                    if (timer >= RELEASE_COUNT - 1'b1) begin
                        next_state = SRS_RUN;
                    end else begin
                        next_timer = timer + 1'b1;
                    end
                end
                SRS_RUN: begin
                    if (button_fall) begin
                        next_state = SRS_TIMING;
                        next_timer = '0;
                    end
                end
                default: begin
                    next_state = SRS_HOLD;
                end
            endcase
        end
    end

    always_comb begin
        next_prog_timer = prog_timer;
        next_program_start = 1'b0;
        if (prog_timer != '0) begin
            // A running cycle finishes regardless of reset
            next_prog_timer = prog_timer - 1'b1;
        end else if (program_request && !reset_active) begin
            next_program_start = 1'b1;
            next_prog_timer = PROGRAM_COUNT;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SRS_HOLD;
            timer <= '0;
            prog_timer <= '0;
            program_start <= 1'b0;
            button_prev <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            prog_timer <= next_prog_timer;
            program_start <= next_program_start;
            button_prev <= button_low;
        end
    end

    assign reset_active = (state != SRS_RUN);
    // Open drain: drive the active level only, leave release to the resistor
    assign reset_pin_out = ACTIVE_LOW ? 1'b0 : 1'b1;
    assign reset_pin_oe = reset_active;
    assign program_busy = (prog_timer != '0);
    assign xfer_abort = reset_active && xfer_busy;
    assign bus_disable = reset_active || program_busy;

    a_trip_asserts: assert property (@(posedge clk) disable iff (rst)
        $rose(under_trip_level) ##1 under_trip_level [*7] |-> ##[0:2] reset_active)
        else $error("reset not asserted after undervoltage");
    a_glitch_ignored: assert property (@(posedge clk) disable iff (rst)
        state == SRS_RUN && $rose(under_trip_level) ##1 under_trip_level [*6]
        ##1 !under_trip_level |-> ##1 !reset_active)
        else $error("short supply dip caused reset");
    a_hold_min: assert property (@(posedge clk) disable iff (rst)
        $fell(reset_active) |-> $past(timer) == RELEASE_COUNT - 1'b1)
        else $error("reset released before timeout");
    a_release_drive: assert property (@(posedge clk) disable iff (rst)
        reset_pin_oe == reset_active)
        else $error("pin drive disagrees with reset state");
    a_button_restart: assert property (@(posedge clk) disable iff (rst)
        button_fall && !under_clean |=> reset_active && timer == '0)
        else $error("button edge did not restart timeout");
    a_abort_xfer: assert property (@(posedge clk) disable iff (rst)
        reset_active && xfer_busy |-> xfer_abort && bus_disable)
        else $error("transfer not aborted in reset");
    a_no_start: assert property (@(posedge clk) disable iff (rst)
        program_start |-> !$past(reset_active) && program_busy)
        else $error("program cycle started in reset");
    a_prog_runs: assert property (@(posedge clk) disable iff (rst)
        program_busy && prog_timer != 1 |=> program_busy)
        else $error("program cycle cut short");
    a_bus_off_prog: assert property (@(posedge clk) disable iff (rst)
        program_busy |-> bus_disable)
        else $error("bus enabled during program cycle");
    c_release: cover property (@(posedge clk) $fell(reset_active));
    c_button: cover property (@(posedge clk) button_fall);
    c_prog: cover property (@(posedge clk) program_start);
    c_abort: cover property (@(posedge clk) xfer_abort);
endmodule : srs_supervisor
`default_nettype wire

// File: tb/srs_button_model.sv
/*
 * Push-button and pull-up on the reset pin, the far side of the block.
 * Assumes the active-low variant; the pin is pulled up when nobody drives.
 */
`default_nettype none
module srs_button_model (
    input wire logic press,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wired-AND: button or device pulling low wins over the pull-up
    assign pin_level = (press || (pin_oe && !pin_out)) ? 1'b0 : 1'b1;
endmodule : srs_button_model
`default_nettype wire

// File: tb/supply_reset_supervisor_tb_top.sv
/*
 * Self-checking bench for the supervisor with shortened counts.
 * Assumes the button model resolves the pin level.
 */
`default_nettype none
module supply_reset_supervisor_tb_top import srs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 100;
    localparam int PC = 50;
    logic clk = 0, rst = 1, low = 0, press = 0, busy = 0, preq = 0;
    logic pin_out, pin_oe, r_act, abort, bdis, pstart, pbusy, pin;
    logic pin_out_h, oe_h, r_act_h;
    int error_cnt = 0, check_count = 0, n, m;
    srs_supervisor #(.ACTIVE_LOW(1'b1), .RELEASE_COUNT(TIMER_W'(RC)),
        .PROGRAM_COUNT(TIMER_W'(PC))) u_srs_supervisor (.clk(clk), .rst(rst),
        .under_trip_level(low), .reset_pin_in(pin), .reset_pin_out(pin_out),
        .reset_pin_oe(pin_oe), .reset_active(r_act), .xfer_busy(busy),
        .program_request(preq), .xfer_abort(abort), .bus_disable(bdis),
        .program_start(pstart), .program_busy(pbusy));
    srs_button_model u_srs_button_model (.press(press), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_level(pin));
    // Active-high variant sees the shared pin, so a press must leave it alone
    srs_supervisor #(.ACTIVE_LOW(1'b0), .RELEASE_COUNT(TIMER_W'(RC)),
        .PROGRAM_COUNT(TIMER_W'(PC))) u_srs_supervisor_hi (.clk(clk), .rst(rst),
        .under_trip_level(low), .reset_pin_in(pin), .reset_pin_out(pin_out_h),
        .reset_pin_oe(oe_h), .reset_active(r_act_h), .xfer_busy(busy),
        .program_request(preq), .xfer_abort(), .bus_disable(),
        .program_start(), .program_busy());
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Signal picked by number, so no task needs a reference argument
    function automatic logic pick(input int sel);
        if (sel == 0) begin
            return r_act;
        end else if (sel == 1) begin
            return pstart;
        end
        return pbusy;
    endfunction : pick
    task automatic wt(input int sel, input logic v, output int k);
        k = 0;
        while (pick(sel) !== v && k < 2000) begin
            @(negedge clk);
            k++;
        end
    endtask : wt
    task automatic pulse(input bit btn, input int len);
        @(posedge clk);
        if (btn) begin
            press <= 1'b1;
        end else begin
            low <= 1'b1;
        end
        repeat (len) @(posedge clk);
        press <= 1'b0;
        low <= 1'b0;
    endtask : pulse
    // Short pulses must leave reset untouched
    task automatic t_quiet(input bit btn, input int len);
        logic seen;
        seen = 1'b0;
        pulse(btn, len);
        repeat (40) begin
            @(negedge clk);
            seen |= r_act;
        end
        chk(seen, 1'b0);
    endtask : t_quiet
    task automatic t_brown;
        @(posedge clk);
        low <= 1'b1;
        wt(0, 1'b1, n);
        chk(n <= TRIP_DELAY_CYC, 1'b1);
        chk(pin, 1'b0);
        chk(r_act_h && oe_h && pin_out_h, 1'b1);
        @(posedge clk);
        busy <= 1'b1;
        preq <= 1'b1;
        repeat (10) @(negedge clk);
        chk(abort, 1'b1);
        chk(bdis, 1'b1);
        chk(pstart, 1'b0);
        chk(pbusy, 1'b0);
        @(posedge clk);
        {busy, preq, low} <= 3'b000;
        wt(0, 1'b0, n);
        chk(n >= RC && n <= RC + 14, 1'b1);
        chk(pin_oe, 1'b0);
    endtask : t_brown
    task automatic t_button;
        // Pin filter still shows the self-driven low just after release
        repeat (BUTTON_GLITCH_CYC + 8) @(negedge clk);
        @(posedge clk);
        press <= 1'b1;
        wt(0, 1'b1, n);
        chk(n >= BUTTON_GLITCH_CYC && n <= BUTTON_GLITCH_CYC + 4, 1'b1);
        chk(r_act_h, 1'b0);
        @(posedge clk);
        press <= 1'b0;
        wt(0, 1'b0, n);
        chk(n >= RC - 1 && n <= RC + 2, 1'b1);
        chk(pin, 1'b1);
    endtask : t_button
    task automatic t_program;
        @(posedge clk);
        preq <= 1'b1;
        wt(1, 1'b1, n);
        chk(n <= 4, 1'b1);
        chk(bdis, 1'b1);
        @(posedge clk);
        preq <= 1'b0;
        low <= 1'b1;
        wt(0, 1'b1, n);
        chk(pbusy, 1'b1);
        wt(2, 1'b0, m);
        chk(n + m >= PC - 3 && n + m <= PC + 3, 1'b1);
        @(posedge clk);
        low <= 1'b0;
        wt(0, 1'b0, n);
        chk(n >= RC && n <= RC + 14, 1'b1);
    endtask : t_program
    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wt(0, 1'b0, n);
        chk(n >= RC && n <= RC + 14, 1'b1);
        t_quiet(1'b0, SUPPLY_GLITCH_CYC);
        t_quiet(1'b1, BUTTON_GLITCH_CYC);
        t_brown();
        t_button();
        t_program();
        test_done();
    end
endmodule : supply_reset_supervisor_tb_top
`default_nettype wire
